/* hw/sap_clkgen.sv */
/*
 Bit and frame clock generator for whichever end is clock master.
 Assumes ratio and period come from stable configuration.
*/
`timescale 1ns/1ns
module sap_clkgen (
	input  wire logic        hclk,        // Master clock
	input  wire logic        hresetn,     // Async reset, active low
	input  wire logic [10:0] ratio,       // Master clocks per frame
	input  wire logic [7:0]  period,      // Master clocks per bit
	output logic             bclk_gen,    // Bit clock, rises mid-bit
	output logic             slot_right,  // High in second half-frame
	output logic             frame_pulse  // High during first bit of frame
);
	logic [10:0] mcnt_ff;
	logic [10:0] nxt_mcnt;
	logic [7:0]  bcnt_ff;
	logic [7:0]  nxt_bcnt;
	logic [10:0] half;

	always_comb
	begin
		half = ratio >> 1;
		// RQ10 frame every ratio clocks
		nxt_mcnt = (mcnt_ff >= ratio - 11'h001) ? 11'h000 : mcnt_ff + 11'h001;
		// Bit phase restarts at each half-frame so bits stay frame aligned
		if ((nxt_mcnt == 11'h000) || (nxt_mcnt == half) || (bcnt_ff >= period - 8'h01))
			nxt_bcnt = 8'h00;
		else
			nxt_bcnt = bcnt_ff + 8'h01;
	end

	always_ff @(posedge hclk or negedge hresetn)
	begin
		if (!hresetn)
		begin
			mcnt_ff <= 11'h000;
			bcnt_ff <= 8'h00;
		end
		else
		begin
			mcnt_ff <= nxt_mcnt;
			bcnt_ff <= nxt_bcnt;
		end
	end

	always_ff @(posedge hclk or negedge hresetn)
	begin
		if (!hresetn)
		begin
			bclk_gen    <= 1'b0;
			slot_right  <= 1'b0;
			frame_pulse <= 1'b0;
		end
		else
		begin
			// RQ11 bit rate from divider
			bclk_gen    <= nxt_bcnt >= (period >> 1);
			slot_right  <= nxt_mcnt >= half;
			// RQ8 pulse one bit wide
			frame_pulse <= nxt_mcnt < {3'h0, period};
		end
	end
endmodule // sap_clkgen

/* hw/sap_dac_port.sv */
/*
 DAC end of the serial audio port with an AHB-Lite register slave.
 Assumes hclk is the master clock and link pins are synchronous to it.
*/
// Function
// RQ1: Right-justified: LSB on last bit before frame change
// RQ2: Left-justified: MSB on first rise after transition
// RQ3: I2S: MSB on second rise after transition
// RQ4: Spare bit clocks in a slot ignored
// RQ5: DSP MSB after one or two rises
// RQ6: DSP right word directly follows left word
// RQ7: Slave DSP frame pulse of any width
// RQ8: Master DSP frame pulse one bit wide
// RQ9: Role bit makes clocks inputs or outputs
// RQ10: Master frame rate is master clock over ratio
// RQ11: Divider field sets master bit clock rate
// RQ12: Ratio field: detect or fixed ratio
// RQ13: Detected ratio within 32 master clocks
// RQ14: Data and frame sampled on rising edge
// RQ15: Polarity bits invert bit and frame clocks; in DSP the frame bit selects mode B instead
// RQ16: Word length field, reset 24 bits
// RQ17: Framing field, reset I2S
// RQ18: Master clock kept synchronous, jitter tolerated
// RQ19: Hold standby while ratio keeps changing
// RQ20: Do not change framing while running
// RQ21: Ratios 128fs to 1152fs supported
// RQ22: Link is data, frame and bit clock
`timescale 1ns/1ns
module sap_dac_port (
	input  wire logic        hclk,       // Master clock
	input  wire logic        hresetn,    // Async reset, active low
	input  wire logic        hsel,       // Slave select
	input  wire logic [31:0] haddr,      // Byte address
	input  wire logic [1:0]  htrans,     // Transfer type
	input  wire logic        hwrite,     // Write when high
	input  wire logic [2:0]  hsize,      // Always word here
	input  wire logic [31:0] hwdata,     // Write data
	input  wire logic        hready,     // Bus ready
	output logic             hreadyout,  // Always ready
	output logic [31:0]      hrdata,     // Read data
	output logic             hresp,      // Always OKAY
	sap_if.dev               link,       // Serial audio link
	output logic [31:0]      left_out,   // Last left word, right aligned
	output logic [31:0]      right_out,  // Last right word, right aligned
	output logic             pair_valid  // Pulse: new pair on outputs
);
	logic [15:0] ctl_one_ff;
	logic [15:0] ctl_two_ff;
	logic        wr_pend_ff;
	logic [5:0]  wr_idx_ff;
	logic [31:0] hrdata_ff;
	logic [31:0] rd_word;
	sap_pkg::sap_fmt_t fmt;
	logic        role;
	logic        frame_inv;
	logic        bclk_inv;
	logic [1:0]  wl_sel;
	logic [2:0]  div_code;
	logic [2:0]  ratio_code;
	logic [2:0]  eff_code;
	logic [10:0] ratio;
	logic        gen_bclk;
	logic        gen_right;
	logic        gen_pulse;
	logic        frame_q_ff;
	logic [11:0] per_cnt_ff;
	logic [11:0] meas_ff;
	logic [2:0]  det_code_ff;
	logic        det_lock_ff;
	logic [7:1]  hit;
	logic [2:0]  nxt_det_code;
	logic        bq_ff;
	logic        fsamp_ff;
	logic [6:0]  pos_ff;
	logic [6:0]  nxt_pos;
	logic [31:0] shreg_ff;
	logic        is_dsp;
	logic        lvl;
	logic        is_left;
	logic        rise;
	logic        edge_ev;
	logic [7:0]  end_a;
	logic [7:0]  end_b;
	logic [31:0] word;

	assign hreadyout = 1'b1;
	assign hresp     = 1'b0;
	assign hrdata    = hrdata_ff;

	always_ff @(posedge hclk or negedge hresetn)
	begin
		if (!hresetn)
		begin
			wr_pend_ff <= 1'b0;
			wr_idx_ff  <= 6'h00;
			hrdata_ff  <= 32'h00000000;
		end
		else
		begin
			wr_pend_ff <= hsel & hready & htrans[1] & hwrite;
			wr_idx_ff  <= haddr[7:2];
			if (hsel & hready & htrans[1] & !hwrite)
				hrdata_ff <= rd_word;
		end
	end

	// RQ16 RQ17 reset to 24 bits, I2S
	always_ff @(posedge hclk or negedge hresetn)
	begin
		if (!hresetn)
		begin
			ctl_one_ff <= sap_pkg::CTL_ONE_RESET;
			ctl_two_ff <= sap_pkg::CTL_TWO_RESET;
		end
		else if (wr_pend_ff)
		begin
			if (wr_idx_ff == sap_pkg::CTL_ONE_IDX)
				ctl_one_ff <= hwdata[15:0] & sap_pkg::CTL_ONE_MASK;
			if (wr_idx_ff == sap_pkg::CTL_TWO_IDX)
				ctl_two_ff <= hwdata[15:0] & sap_pkg::CTL_TWO_MASK;
		end
	end

	always_comb
	begin
		rd_word = 32'h00000000;
		case (haddr[7:2])
			sap_pkg::CTL_ONE_IDX: rd_word = {16'h0000, ctl_one_ff};
			sap_pkg::CTL_TWO_IDX: rd_word = {16'h0000, ctl_two_ff};
			sap_pkg::STATUS_IDX:
			begin
				rd_word[sap_pkg::DET_CODE_LSB +: 3]   = eff_code;
				rd_word[sap_pkg::DET_LOCK_BIT]        = det_lock_ff;
				rd_word[sap_pkg::DET_COUNT_LSB +: 12] = meas_ff;
			end
			default: rd_word = 32'h00000000;
		endcase
	end

	assign fmt        = sap_pkg::sap_fmt_t'(ctl_one_ff[sap_pkg::FMT_LSB +: 2]);
	assign role       = ctl_one_ff[sap_pkg::ROLE_BIT];
	assign frame_inv  = ctl_one_ff[sap_pkg::FRAME_INV_BIT];
	assign bclk_inv   = ctl_one_ff[sap_pkg::BCLK_INV_BIT];
	assign wl_sel     = ctl_one_ff[sap_pkg::WL_LSB +: 2];
	assign div_code   = ctl_two_ff[sap_pkg::DIV_LSB +: 3];
	assign ratio_code = ctl_two_ff[sap_pkg::RATIO_LSB +: 3];

	// RQ12 RQ21 fixed ratio, detected in slave, fallback in master
	assign eff_code = (ratio_code != 3'h0) ? ratio_code
	                : (role ? sap_pkg::MASTER_AUTO_CODE : det_code_ff);
	assign ratio    = sap_pkg::ratio_of(eff_code);

	sap_clkgen u_clkgen (
		.hclk        (hclk),
		.hresetn     (hresetn),
		.ratio       (ratio),
		.period      (sap_pkg::bclk_period(div_code, ratio)),
		.bclk_gen    (gen_bclk),
		.slot_right  (gen_right),
		.frame_pulse (gen_pulse)
	);

	// RQ9 master drives both clocks
	assign link.dev_bclk_oe  = role;
	assign link.dev_frame_oe = role;
	// RQ15 master bit clock inverted on request
	assign link.dev_bclk_out = gen_bclk ^ bclk_inv;
	assign link.dev_frame_out = is_dsp ? gen_pulse : (gen_right ^ (fmt != sap_pkg::FMT_I2S) ^ frame_inv);

	// RQ13 frame period in master clocks, rise to rise
	always_ff @(posedge hclk or negedge hresetn)
	begin
		if (!hresetn)
		begin
			frame_q_ff <= 1'b0;
			per_cnt_ff <= 12'h000;
			meas_ff    <= 12'h000;
		end
		else
		begin
			frame_q_ff <= link.frame;
			if (link.frame & !frame_q_ff)
			begin
				meas_ff    <= per_cnt_ff + 12'h001;
				per_cnt_ff <= 12'h000;
			end
			else if (per_cnt_ff != sap_pkg::PERIOD_MAX)
				per_cnt_ff <= per_cnt_ff + 12'h001;
		end
	end

	// RQ18 window absorbs master clock jitter
	for (genvar k = 1; k < 8; k++)
	begin : g_hit
		logic [11:0] target;
		assign target = {1'b0, sap_pkg::ratio_of(3'(k))};
		assign hit[k] = (meas_ff + sap_pkg::DETECT_TOL >= target)
		             && (meas_ff <= target + sap_pkg::DETECT_TOL);
	end

	always_comb
	begin
		nxt_det_code = det_code_ff;
		for (int i = 7; i >= 1; i--)
			if (hit[i])
				nxt_det_code = 3'(i);
	end

	always_ff @(posedge hclk or negedge hresetn)
	begin
		if (!hresetn)
		begin
			det_code_ff <= sap_pkg::MASTER_AUTO_CODE;
			det_lock_ff <= 1'b0;
		end
		else
		begin
			det_code_ff <= nxt_det_code;
			det_lock_ff <= |hit;
		end
	end

	always_comb
	begin
		is_dsp  = fmt == sap_pkg::FMT_DSP;
		// RQ15 frame polarity outside DSP
		lvl     = link.frame ^ (frame_inv & !is_dsp);
		is_left = (fmt == sap_pkg::FMT_I2S) ? !lvl : lvl;
		// RQ14 RQ15 sample on chosen bit clock edge
		rise    = (link.bclk ^ bclk_inv) & !bq_ff;
		// RQ7 only the pulse's rising edge counts
		edge_ev = is_dsp ? (link.frame & !fsamp_ff) : (lvl != (fsamp_ff ^ (frame_inv & !is_dsp)));
		nxt_pos = edge_ev ? 7'h00 : ((pos_ff == sap_pkg::POS_MAX) ? pos_ff : pos_ff + 7'h01);
		// RQ2 RQ3 RQ5 last bit follows from start and length
		end_a   = {7'h00, sap_pkg::msb_start(fmt, frame_inv)}
		        + {2'h0, sap_pkg::wl_bits(wl_sel)} - 8'h01;
		// RQ6 right word contiguous with left
		end_b   = end_a + {2'h0, sap_pkg::wl_bits(wl_sel)};
		word    = {shreg_ff[30:0], link.sdata} & sap_pkg::wl_mask(wl_sel);
	end

	always_ff @(posedge hclk or negedge hresetn)
	begin
		if (!hresetn)
		begin
			bq_ff    <= 1'b0;
			fsamp_ff <= 1'b0;
			pos_ff   <= 7'h00;
			shreg_ff <= 32'h00000000;
		end
		else
		begin
			bq_ff <= link.bclk ^ bclk_inv;
			if (rise)
			begin
				fsamp_ff <= link.frame;
				pos_ff   <= nxt_pos;
				shreg_ff <= {shreg_ff[30:0], link.sdata};
			end
		end
	end

	// RQ4 words taken at fixed positions, or at the frame change in RJ, spare bits never stored
	always_ff @(posedge hclk or negedge hresetn)
	begin
		if (!hresetn)
		begin
			left_out   <= 32'h00000000;
			right_out  <= 32'h00000000;
			pair_valid <= 1'b0;
		end
		else
		begin
			pair_valid <= 1'b0;
			if (rise)
			begin
				// RQ1 slot closes at frame change, last bits are the word
				if (fmt == sap_pkg::FMT_RJ)
				begin
					if (edge_ev & !is_left)
						left_out <= shreg_ff & sap_pkg::wl_mask(wl_sel);
					else if (edge_ev)
					begin
						right_out  <= shreg_ff & sap_pkg::wl_mask(wl_sel);
						pair_valid <= 1'b1;
					end
				end
				else if ({1'b0, nxt_pos} == end_a)
				begin
					if (is_dsp | is_left)
						left_out <= word;
					else
					begin
						right_out  <= word;
						pair_valid <= 1'b1;
					end
				end
				else if (is_dsp && ({1'b0, nxt_pos} == end_b))
				begin
					right_out  <= word;
					pair_valid <= 1'b1;
				end
			end
		end
	end
endmodule // sap_dac_port

/* hw/sap_if.sv */
/*
 Serial audio link between the DAC port and the audio source.
 Assumes at most one end enables its clock drivers at a time.
*/
`timescale 1ns/1ns
interface sap_if;
	// RQ22 data, frame, bit clock
	logic sdata;         // Serial audio input, source to DAC
	logic dev_bclk_out;  // Bit clock driven by DAC
	logic dev_bclk_oe;   // DAC drives bit clock
	logic dev_frame_out; // Frame clock driven by DAC
	logic dev_frame_oe;  // DAC drives frame clock
	logic src_bclk_out;  // Bit clock driven by source
	logic src_bclk_oe;   // Source drives bit clock
	logic src_frame_out; // Frame clock driven by source
	logic src_frame_oe;  // Source drives frame clock
	logic bclk;          // Resolved bit clock wire
	logic frame;         // Resolved frame clock wire

	// Undriven wires read low
	assign bclk  = dev_bclk_oe ? dev_bclk_out : (src_bclk_oe & src_bclk_out);
	assign frame = dev_frame_oe ? dev_frame_out : (src_frame_oe & src_frame_out);

	modport dev (
		input  sdata, bclk, frame,
		output dev_bclk_out, dev_bclk_oe, dev_frame_out, dev_frame_oe
	);
	modport src (
		output sdata, src_bclk_out, src_bclk_oe, src_frame_out, src_frame_oe,
		input  bclk, frame
	);
endinterface

/* hw/sap_pkg.sv */
/*
 Shared constants, encodings and helpers for the stereo serial audio port.
 Assumes hclk is the master clock from which every frame and bit rate is set.
*/
package sap_pkg;
	// Register word indices; the byte address is four times the index
	localparam logic [5:0]  CTL_ONE_IDX      = 6'h03;
	localparam logic [5:0]  CTL_TWO_IDX      = 6'h04;
	localparam logic [5:0]  STATUS_IDX       = 6'h08;
	localparam int          ROLE_BIT         = 7;
	localparam int          FRAME_INV_BIT    = 6;
	localparam int          BCLK_INV_BIT     = 5;
	localparam int          WL_LSB           = 3;
	localparam int          FMT_LSB          = 0;
	localparam int          DIV_LSB          = 3;
	localparam int          RATIO_LSB        = 0;
	localparam int          DET_CODE_LSB     = 0;
	localparam int          DET_LOCK_BIT     = 3;
	localparam int          DET_COUNT_LSB    = 16;
	localparam logic [15:0] CTL_ONE_MASK     = 16'h00fb;
	localparam logic [15:0] CTL_TWO_MASK     = 16'h003f;
	localparam logic [15:0] CTL_ONE_RESET    = 16'h0012;
	localparam logic [15:0] CTL_TWO_RESET    = 16'h0000;
	localparam logic [11:0] DETECT_TOL       = 12'h020;
	localparam logic [2:0]  MASTER_AUTO_CODE = 3'h3;
	localparam logic [7:0]  MIN_BCLK_PERIOD  = 8'h02;
	localparam logic [6:0]  POS_MAX          = 7'h7f;
	localparam logic [11:0] PERIOD_MAX       = 12'hfff;

	typedef enum logic [1:0] {FMT_RJ, FMT_LJ, FMT_I2S, FMT_DSP} sap_fmt_t;

	// Master clocks per frame for a ratio code; code 0 means detect
	function automatic logic [10:0] ratio_of(input logic [2:0] code);
		case (code)
			3'h1:    ratio_of = 11'h080;
			3'h2:    ratio_of = 11'h0c0;
			3'h3:    ratio_of = 11'h100;
			3'h4:    ratio_of = 11'h180;
			3'h5:    ratio_of = 11'h200;
			3'h6:    ratio_of = 11'h300;
			3'h7:    ratio_of = 11'h480;
			default: ratio_of = 11'h000;
		endcase
	endfunction

	function automatic logic [5:0] wl_bits(input logic [1:0] code);
		case (code)
			2'h0:    wl_bits = 6'h10;
			2'h1:    wl_bits = 6'h14;
			2'h2:    wl_bits = 6'h18;
			default: wl_bits = 6'h20;
		endcase
	endfunction

	function automatic logic [31:0] wl_mask(input logic [1:0] code);
		case (code)
			2'h0:    wl_mask = 32'h0000ffff;
			2'h1:    wl_mask = 32'h000fffff;
			2'h2:    wl_mask = 32'h00ffffff;
			default: wl_mask = 32'hffffffff;
		endcase
	endfunction

	// Master clocks per bit; reserved codes fall back to the /4 rate
	function automatic logic [7:0] bclk_period(input logic [2:0] div, input logic [10:0] ratio);
		logic [7:0] p;
		case (div)
			3'h1:    p = 8'h08;
			3'h2:    p = 8'(ratio >> 5);
			3'h3:    p = 8'(ratio >> 6);
			3'h4:    p = 8'(ratio >> 7);
			default: p = 8'h04;
		endcase
		bclk_period = (p < MIN_BCLK_PERIOD) ? MIN_BCLK_PERIOD : p;
	endfunction

	// Position of the first data bit after the frame mark
	function automatic logic msb_start(input sap_fmt_t fmt, input logic mode_b);
		msb_start = (fmt == FMT_I2S) || ((fmt == FMT_DSP) && !mode_b);
	endfunction
endpackage

/* hw/sap_source.sv */
/*
 Audio source end: sends left/right words on the serial link, MSB first.
 Assumes the DAC's role is the opposite of role_master and that
 configuration matches the DAC's registers.
*/
`timescale 1ns/1ns
module sap_source (
	input  wire logic        hclk,        // Master clock
	input  wire logic        hresetn,     // Async reset, active low
	sap_if.src               link,        // Serial audio link
	input  wire logic        role_master, // Source makes the clocks
	input  wire logic [1:0]  fmt_sel,     // Framing code
	input  wire logic [1:0]  wl_sel,      // Word length code
	input  wire logic        frame_inv,   // Frame polarity or DSP mode B
	input  wire logic        bclk_inv,    // Bit clock polarity
	input  wire logic [2:0]  ratio_code,  // Ratio code when master
	input  wire logic [2:0]  div_code,    // Bit clock divider when master
	input  wire logic [31:0] left_in,     // Next left word, right aligned
	input  wire logic [31:0] right_in,    // Next right word, right aligned
	output logic             pair_taken   // Pulse: inputs latched
);
	sap_pkg::sap_fmt_t fmt;
	logic [10:0] ratio;
	logic        gen_bclk;
	logic        gen_right;
	logic        gen_pulse;
	logic        bq_ff;
	logic        fq_ff;
	logic [6:0]  pos_ff;
	logic [6:0]  slot_len_ff;
	logic [31:0] lw_ff;
	logic [31:0] rw_ff;
	logic        sdata_ff;
	logic        is_dsp;
	logic        lvl;
	logic        is_left;
	logic        fall;
	logic        ev;
	logic        load;
	logic [6:0]  up_pos;
	logic [7:0]  idx;
	logic [7:0]  rj_rem;
	logic [7:0]  wl;
	logic [31:0] cur_l;
	logic [31:0] cur_r;
	logic        nxt_bit;

	assign fmt   = sap_pkg::sap_fmt_t'(fmt_sel);
	assign ratio = (ratio_code == 3'h0) ? sap_pkg::ratio_of(sap_pkg::MASTER_AUTO_CODE)
	                                    : sap_pkg::ratio_of(ratio_code);

	// RQ18 frames from master clock
	sap_clkgen u_clkgen (
		.hclk        (hclk),
		.hresetn     (hresetn),
		.ratio       (ratio),
		.period      (sap_pkg::bclk_period(div_code, ratio)),
		.bclk_gen    (gen_bclk),
		.slot_right  (gen_right),
		.frame_pulse (gen_pulse)
	);

	assign link.src_bclk_oe  = role_master;
	assign link.src_frame_oe = role_master;
	assign link.src_bclk_out = gen_bclk ^ bclk_inv;
	// RQ7 short pulse, early fall
	assign link.src_frame_out = is_dsp ? gen_pulse : (gen_right ^ (fmt != sap_pkg::FMT_I2S) ^ frame_inv);
	assign link.sdata        = sdata_ff;

	always_comb
	begin
		is_dsp  = fmt == sap_pkg::FMT_DSP;
		lvl     = link.frame ^ (frame_inv & !is_dsp);
		is_left = (fmt == sap_pkg::FMT_I2S) ? !lvl : lvl;
		fall    = !(link.bclk ^ bclk_inv) & bq_ff;
		ev      = is_dsp ? (link.frame & !fq_ff) : (lvl != (fq_ff ^ (frame_inv & !is_dsp)));
		load    = fall & ev & (is_dsp | is_left);
		cur_l   = load ? left_in : lw_ff;
		cur_r   = load ? right_in : rw_ff;
		up_pos  = ev ? 7'h00 : ((pos_ff == sap_pkg::POS_MAX) ? pos_ff : pos_ff + 7'h01);
		wl      = {2'h0, sap_pkg::wl_bits(wl_sel)};
		idx     = {1'b0, up_pos} - {7'h00, sap_pkg::msb_start(fmt, frame_inv)};
		rj_rem  = {1'b0, slot_len_ff} - 8'h01 - {1'b0, up_pos};
		nxt_bit = 1'b0;
		// RQ1 LSB on last bit of slot
		if (fmt == sap_pkg::FMT_RJ)
		begin
			if (rj_rem < wl)
				nxt_bit = is_left ? cur_l[rj_rem[4:0]] : cur_r[rj_rem[4:0]];
		end
		// RQ6 right word follows left directly
		else if (is_dsp)
		begin
			if (idx < wl)
				nxt_bit = cur_l[5'(wl - 8'h01 - idx)];
			else if (idx < {wl[6:0], 1'b0})
				nxt_bit = cur_r[5'({wl[6:0], 1'b0} - 8'h01 - idx)];
		end
		// RQ2 RQ3 MSB at start position
		else if (idx < wl)
			nxt_bit = is_left ? cur_l[5'(wl - 8'h01 - idx)] : cur_r[5'(wl - 8'h01 - idx)];
	end

	always_ff @(posedge hclk or negedge hresetn)
	begin
		if (!hresetn)
			bq_ff <= 1'b0;
		else
			bq_ff <= link.bclk ^ bclk_inv;
	end

	// Data changes on falling edge, stable at the DAC's sampling edge
	always_ff @(posedge hclk or negedge hresetn)
	begin
		if (!hresetn)
		begin
			fq_ff       <= 1'b0;
			pos_ff      <= 7'h00;
			slot_len_ff <= 7'h00;
			sdata_ff    <= 1'b0;
		end
		else if (fall)
		begin
			fq_ff    <= link.frame;
			pos_ff   <= up_pos;
			sdata_ff <= nxt_bit;
			if (ev)
				slot_len_ff <= (pos_ff == sap_pkg::POS_MAX) ? pos_ff : pos_ff + 7'h01;
		end
	end

	always_ff @(posedge hclk or negedge hresetn)
	begin
		if (!hresetn)
		begin
			lw_ff      <= 32'h00000000;
			rw_ff      <= 32'h00000000;
			pair_taken <= 1'b0;
		end
		else
		begin
			pair_taken <= load;
			if (load)
			begin
				lw_ff <= left_in;
				rw_ff <= right_in;
			end
		end
	end
endmodule // sap_source

/* testbench/sap_link_props.sv */
/*
 Checker for the serial link joining the DAC port and the audio source.
 Assumes the plain link signals of the one interface between both ends.
*/
`timescale 1ns/1ns
module sap_link_props (
	input wire logic hclk,          // Master clock
	input wire logic hresetn,       // Async reset, active low
	input wire logic bclk,          // Resolved bit clock
	input wire logic dev_bclk_out,  // DAC bit clock
	input wire logic dev_bclk_oe,   // DAC drives bit clock
	input wire logic dev_frame_out, // DAC frame clock
	input wire logic dev_frame_oe,  // DAC drives frame clock
	input wire logic src_bclk_oe,   // Source drives bit clock
	input wire logic src_frame_oe   // Source drives frame clock
);
	logic        frm_q_ff;
	logic [11:0] per_ff;
	logic [1:0]  seen_ff;
	logic        frm_rise;

	default clocking cb @(posedge hclk); endclocking
	default disable iff (!hresetn);

	assign frm_rise = dev_frame_out & ~frm_q_ff;

	always_ff @(posedge hclk or negedge hresetn)
	begin
		if (!hresetn)
			frm_q_ff <= 1'b0;
		else
			frm_q_ff <= dev_frame_out;
	end

	// First period after the driver comes on may be partial
	always_ff @(posedge hclk or negedge hresetn)
	begin
		if (!hresetn)
		begin
			per_ff  <= 12'h000;
			seen_ff <= 2'h0;
		end
		else if (!dev_frame_oe)
		begin
			per_ff  <= 12'h000;
			seen_ff <= 2'h0;
		end
		else
		begin
			per_ff <= frm_rise ? 12'h001 : per_ff + 12'h001;
			if (frm_rise && seen_ff != 2'h2)
				seen_ff <= seen_ff + 2'h1;
		end
	end

	sequence s_bclk_moves;
		##[1:40] $changed(dev_bclk_out);
	endsequence

	sequence s_frame_moves;
		dev_frame_oe && $past(dev_frame_oe) && $changed(dev_frame_out);
	endsequence

	bclk_excl_a: assert property (!(dev_bclk_oe && src_bclk_oe))
		else $error("bit clock driven by both ends");
	frame_excl_a: assert property (!(dev_frame_oe && src_frame_oe))
		else $error("frame clock driven by both ends");
	dev_role_a: assert property (dev_bclk_oe == dev_frame_oe)
		else $error("DAC drives only one of its clocks");
	src_role_a: assert property (src_bclk_oe == src_frame_oe)
		else $error("source drives only one of its clocks");
	idle_low_a: assert property (!dev_bclk_oe && !src_bclk_oe |-> !bclk)
		else $error("undriven bit clock not low");
	frame_edge_a: assert property (s_frame_moves |-> $changed(dev_bclk_out))
		else $error("frame moved away from a bit clock edge");
	bclk_moves_a: assert property (dev_bclk_oe |-> s_bclk_moves)
		else $error("master bit clock stalled");
	frame_period_a: assert property (frm_rise && seen_ff == 2'h2 |->
		per_ff inside {12'h080, 12'h0c0, 12'h100, 12'h180, 12'h200, 12'h300, 12'h480})
		else $error("master frame period not a listed ratio");
endmodule // sap_link_props

/* testbench/tb_sap_dac_port.sv */
/*
 Testbench: DAC port and audio source joined by one link, AHB-Lite master.
 Assumes hclk is the master clock of both ends.
*/
`timescale 1ns/1ns
`define CHK(nm, ex, gt) begin n_checks++; if ((gt) !== (ex)) begin bad_count++; \
	$display("CHECK FAILED %s exp %h got %h", nm, ex, gt); end end
module tb_sap_dac_port;
	typedef struct packed {
		logic        mst;
		logic [1:0]  fmt;
		logic [1:0]  wl;
		logic        finv;
		logic        binv;
		logic [2:0]  div;
		logic [2:0]  ratio;
		logic [31:0] word;
	} sap_row_t;
	// Junk above the word length must not reach the outputs
	localparam sap_row_t ROWS [10] = '{
		'{1'b1, 2'h0, 2'h0, 1'b0, 1'b0, 3'h4, 3'h1, 32'hffffa5c3},
		'{1'b1, 2'h1, 2'h1, 1'b0, 1'b0, 3'h0, 3'h3, 32'h123c3a51},
		'{1'b1, 2'h2, 2'h2, 1'b0, 1'b1, 3'h0, 3'h3, 32'h00f0e1d2},
		'{1'b1, 2'h3, 2'h0, 1'b0, 1'b0, 3'h0, 3'h3, 32'h12348001},
		'{1'b1, 2'h3, 2'h2, 1'b1, 1'b0, 3'h3, 3'h4, 32'h00800001},
		'{1'b0, 2'h2, 2'h3, 1'b0, 1'b0, 3'h4, 3'h3, 32'h80000001},
		'{1'b0, 2'h1, 2'h2, 1'b1, 1'b1, 3'h0, 3'h3, 32'hffa5a5a5},
		'{1'b0, 2'h3, 2'h3, 1'b1, 1'b0, 3'h4, 3'h3, 32'hc0000003},
		'{1'b0, 2'h0, 2'h2, 1'b0, 1'b0, 3'h1, 3'h5, 32'h00400002},
		'{1'b0, 2'h1, 2'h0, 1'b0, 1'b0, 3'h0, 3'h7, 32'h00008421}};
	localparam int RAT [8] = '{256, 128, 192, 256, 384, 512, 768, 1152};

	logic        hclk = 1'b0, hresetn = 1'b0, hsel = 1'b0, hwrite = 1'b0;
	logic        role_master = 1'b0, frame_inv = 1'b0, bclk_inv = 1'b0;
	logic        hready, hreadyout, hresp, pair_valid, pair_taken;
	logic [1:0]  htrans = 2'h0, fmt_sel = 2'h2, wl_sel = 2'h2;
	logic [2:0]  hsize = 3'h2, ratio_code = 3'h3, div_code = 3'h0;
	logic [31:0] haddr = 32'h0, hwdata = 32'h0, left_in = 32'h0, right_in = 32'h0;
	logic [31:0] hrdata, left_out, right_out, rd, mask;
	logic [11:0] per;
	int          bad_count = 0, n_checks = 0, cyc = 0, n_taken = 0;
	sap_row_t    r;

	sap_if i_sap_if ();
	sap_dac_port i_sap_dac_port (.hclk(hclk), .hresetn(hresetn), .hsel(hsel),
		.haddr(haddr), .htrans(htrans), .hwrite(hwrite), .hsize(hsize), .hwdata(hwdata),
		.hready(hready), .hreadyout(hreadyout), .hrdata(hrdata), .hresp(hresp),
		.link(i_sap_if), .left_out(left_out), .right_out(right_out),
		.pair_valid(pair_valid));
	sap_source i_sap_source (.hclk(hclk), .hresetn(hresetn), .link(i_sap_if),
		.role_master(role_master), .fmt_sel(fmt_sel), .wl_sel(wl_sel),
		.frame_inv(frame_inv), .bclk_inv(bclk_inv), .ratio_code(ratio_code),
		.div_code(div_code), .left_in(left_in), .right_in(right_in),
		.pair_taken(pair_taken));
	sap_link_props i_sap_link_props (.hclk(hclk), .hresetn(hresetn),
		.bclk(i_sap_if.bclk), .dev_bclk_out(i_sap_if.dev_bclk_out),
		.dev_bclk_oe(i_sap_if.dev_bclk_oe), .dev_frame_out(i_sap_if.dev_frame_out),
		.dev_frame_oe(i_sap_if.dev_frame_oe), .src_bclk_oe(i_sap_if.src_bclk_oe),
		.src_frame_oe(i_sap_if.src_frame_oe));

	assign hready = hreadyout;
	always #10 hclk = ~hclk;

	task test_done;
		$display("checks %0d mismatches %0d", n_checks, bad_count);
		if (bad_count == 0 && n_checks > 0)
			$display("DONE - PASS");
		else
			$display("DONE - FAIL");
		$finish;
	endtask

	always @(posedge hclk)
	begin
		cyc++;
		if (pair_taken === 1'b1)
			n_taken++;
		if (cyc == 90000)
		begin
			bad_count++;
			test_done();
		end
	end

	task automatic ahb(input logic wr, input logic [31:0] a, input logic [31:0] d);
		@(posedge hclk);
		hsel <= 1'b1;
		haddr <= a;
		htrans <= 2'h2;
		hwrite <= wr;
		do @(posedge hclk); while (hreadyout !== 1'b1);
		hsel <= 1'b0;
		htrans <= 2'h0;
		hwdata <= d;
		do @(posedge hclk); while (hreadyout !== 1'b1);
		rd = hrdata;
	endtask

	// Rise to rise of the frame wire, counted in master clocks
	task automatic frame_period(output logic [11:0] n);
		logic p;
		p = 1'b1;
		do begin p = i_sap_if.frame; @(posedge hclk); end while (!(i_sap_if.frame && !p));
		n = 12'h000;
		do begin p = i_sap_if.frame; @(posedge hclk); n++; end while (!(i_sap_if.frame && !p));
	endtask

	task automatic reset_all(input logic src_mst);
		@(posedge hclk);
		hresetn <= 1'b0;
		role_master <= src_mst;
		repeat (4) @(posedge hclk);
		hresetn <= 1'b1;
	endtask

	initial
	begin
		for (int i = 0; i < 10; i++)
		begin
			r = ROWS[i];
			{fmt_sel, wl_sel, frame_inv, bclk_inv} <= {r.fmt, r.wl, r.finv, r.binv};
			{ratio_code, div_code, left_in} <= {r.ratio, r.div, r.word};
			right_in <= r.word ^ 32'h5a5a5a5a;
			reset_all(~r.mst);
			ahb(1'b1, 32'h10, {26'h0, r.div, r.mst ? r.ratio : 3'h0});
			ahb(1'b1, 32'h0c, {24'h0, r.mst, r.finv, r.binv, r.wl, 1'b0, r.fmt});
			// Early pairs may hold garbage while the link settles
			repeat (4) do @(posedge hclk); while (pair_valid !== 1'b1);
			mask = (r.wl == 2'h3) ? 32'hffffffff : 32'hffffffff >> (16 - 4 * r.wl);
			`CHK("left", r.word & mask, left_out)
			`CHK("right", (r.word ^ 32'h5a5a5a5a) & mask, right_out)
			ahb(1'b0, 32'h20, 32'h0);
			`CHK("ratio", {29'h0, r.ratio}, rd & 32'h00000007)
			if (!r.mst) `CHK("lock", 1'b1, rd[3])
			`CHK("count", 12'(RAT[r.ratio]), rd[27:16])
			`CHK("taken", 1'b1, n_taken >= 4 * (i + 1))
			frame_period(per);
			`CHK("period", 12'(RAT[r.ratio]), per)
		end
		reset_all(1'b0);
		ahb(1'b0, 32'h0c, 32'h0);
		`CHK("ctl_one reset", 32'h00000012, rd)
		ahb(1'b0, 32'h10, 32'h0);
		`CHK("ctl_two reset", 32'h00000000, rd)
		ahb(1'b1, 32'h40, 32'hffffffff);
		ahb(1'b0, 32'h40, 32'h0);
		`CHK("unmapped", 32'h00000000, rd)
		ahb(1'b1, 32'h0c, 32'hffffffff);
		ahb(1'b0, 32'h0c, 32'h0);
		`CHK("ctl_one write", 32'h000000fb, rd)
		`CHK("master drive", 1'b1, i_sap_if.dev_bclk_oe)
		`CHK("hresp", 1'b0, hresp)
		frame_period(per);
		`CHK("auto ratio", 12'h100, per)
		test_done();
	end
endmodule // tb_sap_dac_port
